// ==== hw/sfr_top.sv ====
// Serial status flag readout with latched failure flags
// How it works
// R1 - Class 11 in bits 15:14 returns the addressed latched failure byte.
// R2 - Class 00 with bit 7 high returns live levels or live transceiver state instead.
// R3 - Bits 13:9 carry the group address that selects the answering group.
// R4 - Host drives bit 8 high on every read; it is not parity.
// R5 - Reads are never parity checked and never raise a parity error.
// R6 - Host sends bits 6:0 of a read as zeros.
// R7 - Selected byte leaves on serial output in response bits 7:0.
// R8 - A detected fault sets its flag, which then holds regardless of condition.
// R9 - Reading a flag clears it only when its cause has gone.
// R10 - Bit 7 picks first byte when zero, second byte when one.
// R11 - Supply, bus transceiver, pin groups sit at consecutive addresses.
`timescale 1ns/1ns
module sfr_top (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Serial link pins
  input  wire logic       chip_select_bar_i,
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  // Fault conditions, high while present
  input  wire logic [7:0] supply_fault_a_i,
  input  wire logic [7:0] supply_fault_b_i,
  input  wire logic [7:0] bus_fault_a_i,
  input  wire logic [7:0] bus_fault_b_i,
  input  wire logic [7:0] pin_fault_i,
  input  wire logic [7:0] wake_source_i,
  // Live state
  input  wire logic [7:0] bus_live_i,
  input  wire logic [7:0] pin_level_i
);

  // Whole state of the block
  typedef struct packed {
    logic              cs_m;
    logic              cs_s;
    logic              sck_m;
    logic              sck_s;
    logic              sck_p;
    logic              mosi_m;
    logic              mosi_s;
    logic [5:0][7:0]   ev_m;
    logic [5:0][7:0]   ev_s;
    logic [7:0]        live_m;
    logic [7:0]        live_s;
    logic [7:0]        lvl_m;
    logic [7:0]        lvl_s;
    logic [5:0][7:0]   flags;
    logic [15:0]       rx;
    logic [15:0]       tx;
    logic [4:0]        cnt;
    logic [7:0]        resp;
    logic              miso;
    sfr_pkg::sfr_state_e st;
  } sfr_state_s;

  sfr_state_s q;
  sfr_state_s d;
  logic       sck_rise;
  logic       sck_fall;
  logic [3:0] src;
  logic [7:0] resp_sel;

  // Maps a command word to its response source
  function automatic logic [3:0] src_of(input logic [15:0] cmd);
    logic [4:0] addr;
    logic       sel;
    addr   = cmd[13:9]; // [R3]
    sel    = cmd[7]; // [R10]
    src_of = sfr_pkg::SRC_NONE;
    // Bit 8 and bits 6:0 are not examined, so no parity check occurs [R5]
    if (cmd[15:14] == sfr_pkg::CLS_FAIL) begin // [R1]
      case (addr)
        sfr_pkg::ADDR_SUPPLY: begin // [R11]
          src_of = sel ? sfr_pkg::SRC_SUP_B : sfr_pkg::SRC_SUP_A;
        end
        sfr_pkg::ADDR_BUS: begin
          src_of = sel ? sfr_pkg::SRC_BUS_B : sfr_pkg::SRC_BUS_A;
        end
        sfr_pkg::ADDR_PIN: begin
          src_of = sel ? sfr_pkg::SRC_WAKE : sfr_pkg::SRC_PIN_F;
        end
        default: begin
          src_of = sfr_pkg::SRC_NONE;
        end
      endcase
    end else if (cmd[15:14] == sfr_pkg::CLS_LIVE && sel) begin // [R2]
      case (addr)
        sfr_pkg::ADDR_BUS: begin
          src_of = sfr_pkg::SRC_LIVE;
        end
        sfr_pkg::ADDR_PIN: begin
          src_of = sfr_pkg::SRC_LEVEL;
        end
        default: begin
          src_of = sfr_pkg::SRC_NONE;
        end
      endcase
    end
  endfunction

  // Edge detect on the synchronised serial clock
  assign sck_rise = q.sck_s & ~q.sck_p;
  assign sck_fall = ~q.sck_s & q.sck_p;

  // Decode of the last complete command
  assign src = src_of(q.rx);

  // Response byte for the decoded source
  always_comb begin
    resp_sel = 8'h00;
    case (src)
      sfr_pkg::SRC_SUP_A, sfr_pkg::SRC_SUP_B,
      sfr_pkg::SRC_BUS_A, sfr_pkg::SRC_BUS_B,
      sfr_pkg::SRC_PIN_F, sfr_pkg::SRC_WAKE: begin
        resp_sel = q.flags[src[2:0]]; // [R1]
      end
      sfr_pkg::SRC_LIVE: begin
        resp_sel = q.live_s; // [R2]
      end
      sfr_pkg::SRC_LEVEL: begin
        resp_sel = q.lvl_s; // [R2]
      end
      default: begin
        resp_sel = 8'h00;
      end
    endcase
  end

  // Next state
  always_comb begin
    d = q;
    // Two-stage synchronisers for every outside input
    d.cs_m   = chip_select_bar_i;
    d.cs_s   = q.cs_m;
    d.sck_m  = sclk_i;
    d.sck_s  = q.sck_m;
    d.sck_p  = q.sck_s;
    d.mosi_m = mosi_i;
    d.mosi_s = q.mosi_m;
    d.ev_m   = {wake_source_i, pin_fault_i, bus_fault_b_i,
                bus_fault_a_i, supply_fault_b_i, supply_fault_a_i};
    d.ev_s   = q.ev_m;
    d.live_m = bus_live_i;
    d.live_s = q.live_m;
    d.lvl_m  = pin_level_i;
    d.lvl_s  = q.lvl_m;
    // Present faults set their flags and hold them
    d.flags  = q.flags | q.ev_s; // [R8]
    case (q.st)
      sfr_pkg::SFR_IDLE: begin
        if (!q.cs_s) begin
          d.st   = sfr_pkg::SFR_SHIFT;
          d.cnt  = 5'h00;
          d.tx   = {8'h00, q.resp}; // [R7]
          d.miso = 1'b0;
        end
      end
      sfr_pkg::SFR_SHIFT: begin
        if (q.cs_s) begin
          d.st = (q.cnt == sfr_pkg::FRAME_BITS) ? sfr_pkg::SFR_DONE
                                                 : sfr_pkg::SFR_IDLE;
        end else begin
          if (sck_rise) begin
            d.rx  = {q.rx[14:0], q.mosi_s};
            d.cnt = q.cnt + 5'h01;
          end
          if (sck_fall) begin
            d.tx   = {q.tx[14:0], 1'b0};
            d.miso = q.tx[14]; // [R7]
          end
        end
      end
      sfr_pkg::SFR_DONE: begin
        d.st   = sfr_pkg::SFR_IDLE;
        d.resp = resp_sel;
        // Cleared bits whose cause is gone; present causes keep them set
        if (src < sfr_pkg::SRC_LIVE) begin
          d.flags[src[2:0]] = q.ev_s[src[2:0]]; // [R9]
        end
      end
      default: begin
        d.st = sfr_pkg::SFR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q       <= '0;
      q.cs_m  <= 1'b1;
      q.cs_s  <= 1'b1;
      q.flags <= sfr_pkg::FLAGS_RST;
      q.resp  <= sfr_pkg::RESP_RST;
      q.st    <= sfr_pkg::SFR_IDLE;
    end else begin
      q <= d;
    end
  end

  // Serial output, driven while selected
  assign miso_o    = q.miso;
  assign miso_oe_o = (q.st == sfr_pkg::SFR_SHIFT) & ~q.cs_s;

  // Flags never drop outside a read
  chk_flag_hold: assert property ( // [R8]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st != sfr_pkg::SFR_DONE) |=> ((q.flags & $past(q.flags)) == $past(q.flags))
  ) else $error("latched flag dropped without a read");

  // A present fault is latched next cycle
  chk_event_sets: assert property ( // [R8]
    @(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> ((q.flags & $past(q.ev_s)) == $past(q.ev_s))
  ) else $error("present fault not latched");

  // Read leaves exactly the still-present bits
  chk_read_clear: assert property ( // [R9]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && src < sfr_pkg::SRC_LIVE)
    |=> (q.flags[$past(src[2:0])] == $past(q.ev_s[src[2:0]]))
  ) else $error("read clear wrong");

  // Failure read captures the latched byte
  chk_fail_resp: assert property ( // [R1]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_FAIL
     && q.rx[13:9] == sfr_pkg::ADDR_BUS && q.rx[7])
    |=> (q.resp == $past(q.flags[3]))
  ) else $error("second bus fault byte not returned");

  // Supply group first byte at its address
  chk_supply_a: assert property ( // [R11]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_FAIL
     && q.rx[13:9] == sfr_pkg::ADDR_SUPPLY && !q.rx[7])
    |=> (q.resp == $past(q.flags[0]))
  ) else $error("first supply byte not returned");

  // Live read returns live transceiver state
  chk_live_resp: assert property ( // [R2]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_LIVE
     && q.rx[13:9] == sfr_pkg::ADDR_BUS && q.rx[7])
    |=> (q.resp == $past(q.live_s))
  ) else $error("live bus state not returned");

  // Live pin group returns live pin levels
  chk_level_resp: assert property ( // [R2]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_LIVE
     && q.rx[13:9] == sfr_pkg::ADDR_PIN && q.rx[7])
    |=> (q.resp == $past(q.lvl_s))
  ) else $error("live pin levels not returned");

  // Live class with byte select low answers zero
  chk_live_sel_low: assert property ( // [R10]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_LIVE && !q.rx[7])
    |=> (q.resp == 8'h00)
  ) else $error("live read with low select answered nonzero");

  // Pin group second byte holds the wake sources
  chk_pin_second: assert property ( // [R10]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_FAIL
     && q.rx[13:9] == sfr_pkg::ADDR_PIN && q.rx[7])
    |=> (q.resp == $past(q.flags[5]))
  ) else $error("wake source byte not returned");

  // Bus group first byte at the address after supply
  chk_bus_first: assert property ( // [R11]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[15:14] == sfr_pkg::CLS_FAIL
     && q.rx[13:9] == sfr_pkg::ADDR_BUS && !q.rx[7])
    |=> (q.resp == $past(q.flags[2]))
  ) else $error("first bus fault byte not returned");

  // Unknown group answers zero
  chk_unmapped_zero: assert property ( // [R3]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_DONE && q.rx[13:9] != sfr_pkg::ADDR_SUPPLY
     && q.rx[13:9] != sfr_pkg::ADDR_BUS && q.rx[13:9] != sfr_pkg::ADDR_PIN)
    |=> (q.resp == 8'h00)
  ) else $error("unmapped group answered nonzero");

  // Upper response byte is zero
  chk_miso_upper: assert property ( // [R7]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_SHIFT && q.cnt < 5'h08) |-> (q.miso == 1'b0)
  ) else $error("upper response bits not zero");

  // Bit 7 of the response follows the eighth falling edge
  chk_miso_msb: assert property ( // [R7]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_SHIFT && !q.cs_s && sck_fall && q.cnt == 5'h08)
    |=> (q.miso == q.resp[7])
  ) else $error("response bit 7 misplaced");

  // Short frame returns to idle and captures no response
  chk_short_frame: assert property ( // [R5]
    @(posedge clk_i) disable iff (!arst_n_i)
    (q.st == sfr_pkg::SFR_SHIFT && q.cs_s && q.cnt != sfr_pkg::FRAME_BITS)
    |=> (q.st == sfr_pkg::SFR_IDLE) ##1 (q.resp == $past(q.resp, 2))
  ) else $error("short frame was acted on");

endmodule

// ==== pkg/sfr_pkg.sv ====
// Constants and types for the flag readout block
package sfr_pkg;

  // Command class codes in bits 15:14
  localparam logic [1:0] CLS_FAIL = 2'h3;
  localparam logic [1:0] CLS_LIVE = 2'h0;

  // Group addresses in bits 13:9
  localparam logic [4:0] ADDR_SUPPLY = 5'h0f;
  localparam logic [4:0] ADDR_BUS    = 5'h10;
  localparam logic [4:0] ADDR_PIN    = 5'h11;

  // Frame length in serial clock cycles
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // Response source codes
  localparam logic [3:0] SRC_SUP_A  = 4'h0;
  localparam logic [3:0] SRC_SUP_B  = 4'h1;
  localparam logic [3:0] SRC_BUS_A  = 4'h2;
  localparam logic [3:0] SRC_BUS_B  = 4'h3;
  localparam logic [3:0] SRC_PIN_F  = 4'h4;
  localparam logic [3:0] SRC_WAKE   = 4'h5;
  localparam logic [3:0] SRC_LIVE   = 4'h6;
  localparam logic [3:0] SRC_LEVEL  = 4'h7;
  localparam logic [3:0] SRC_NONE   = 4'h8;

  // Values after reset
  localparam logic [47:0] FLAGS_RST = 48'h0000_0000_0000;
  localparam logic [7:0]  RESP_RST  = 8'h00;

  // Frame state, Gray coded along idle, shift, done
  typedef enum logic [1:0] {
    SFR_IDLE  = 2'h0,
    SFR_SHIFT = 2'h1,
    SFR_DONE  = 2'h3
  } sfr_state_e;

endpackage

// ==== verif/sfr_host.sv ====
// SPI master model that issues flag readout frames
`timescale 1ns/1ns
module sfr_host (
  // Pacing clock
  input  wire logic clk_i,
  // Serial link
  output logic      chip_select_bar_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  initial begin
    chip_select_bar_o = 1'h1;
    sclk_o = 1'h0;
    mosi_o = 1'h0;
  end
  // Wait n clocks, step off the edge
  task automatic pace(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One 16 bit mode 0 frame; got is what came back
  task automatic xfer(input logic [1:0] cls, input logic [4:0] adr, input logic sel, output logic [15:0] got);
    logic [15:0] cmd;
    cmd = {cls, adr, 1'h1, sel, 7'h00};
    chip_select_bar_o = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = cmd[i];
      pace(4);
      got[i] = (miso_oe_i === 1'h1) ? miso_i : 1'hx; // Undriven line never matches
      sclk_o = 1'h1;
      pace(4);
      sclk_o = 1'h0;
    end
    pace(2);
    chip_select_bar_o = 1'h1;
    mosi_o = ~mosi_o; // Released line shows no stale bit
    pace(8);
  endtask
  // Frame cut after n clock pulses; the device must ignore it
  task automatic cut(input logic [15:0] cmd, input int n);
    chip_select_bar_o = 1'h0;
    for (int i = 15; i > 15 - n; i--) begin
      mosi_o = cmd[i];
      pace(4);
      sclk_o = 1'h1;
      pace(4);
      sclk_o = 1'h0;
    end
    pace(2);
    chip_select_bar_o = 1'h1;
    mosi_o = ~mosi_o;
    pace(8);
  endtask
endmodule

// ==== verif/sfr_top_tb.sv ====
// Self-checking bench for the flag readout block
`timescale 1ns/1ns
module sfr_top_tb;
  logic        clk_i = 1'h0;
  logic        arst_n_i = 1'h0;
  logic        csb_n, sclk, mosi, miso, oe;
  logic [7:0]  sup_a, sup_b, bus_a, bus_b, pin_f, wake_f;
  logic [7:0]  live_q, lvl_q;
  logic [15:0] g;
  int          bad_count = 0;
  int          checks_done = 0;

  always #50 clk_i = ~clk_i;

  sfr_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .chip_select_bar_i(csb_n), .sclk_i(sclk), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(oe), .supply_fault_a_i(sup_a), .supply_fault_b_i(sup_b),
    .bus_fault_a_i(bus_a), .bus_fault_b_i(bus_b), .pin_fault_i(pin_f), .wake_source_i(wake_f),
    .bus_live_i(live_q), .pin_level_i(lvl_q));
  sfr_host host (.clk_i(clk_i), .chip_select_bar_o(csb_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(oe));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Latch after cause goes, clear on read
  task automatic t_latch();
    sup_a = 8'h81;
    host.pace(6);
    sup_a = 8'h00;
    host.pace(6);
    host.xfer(2'h3, 5'h0f, 1'h0, g);
    host.xfer(2'h3, 5'h0f, 1'h0, g);
    chk("held flag", g, 16'h0081);
    host.xfer(2'h3, 5'h0f, 1'h0, g);
    chk("cleared flag", g, 16'h0000);
  endtask
  // Read with cause still present keeps flag
  task automatic t_hold();
    bus_a = 8'h04;
    host.pace(6);
    for (int k = 0; k < 3; k++) begin
      host.xfer(2'h3, 5'h10, 1'h0, g);
      if (k > 0) chk("present flag", g, 16'h0004);
    end
    bus_a = 8'h00;
    host.pace(6);
    // Cause gone: first read clears, later reads see it gone
    host.xfer(2'h3, 5'h10, 1'h0, g);
    host.xfer(2'h3, 5'h10, 1'h0, g);
    chk("flag after cause", g, 16'h0004);
    host.xfer(2'h3, 5'h10, 1'h0, g);
    chk("gone flag", g, 16'h0000);
  endtask
  // Every group and byte, then an unmapped address
  task automatic t_map();
    sup_a = 8'h50;
    sup_b = 8'h51;
    bus_a = 8'h52;
    bus_b = 8'h53;
    pin_f = 8'h54;
    wake_f = 8'h55;
    host.pace(6);
    sup_a = 8'h00;
    sup_b = 8'h00;
    bus_a = 8'h00;
    bus_b = 8'h00;
    pin_f = 8'h00;
    wake_f = 8'h00;
    host.pace(6);
    for (int k = 0; k < 8; k++) begin
      host.xfer(2'h3, 5'h0f + 5'(k / 2), 1'(k % 2), g);
      if (k > 0 && k < 7) chk("group byte", g, 16'h0050 + 16'(k - 1));
      if (k == 7) chk("unmapped", g, 16'h0000);
    end
  endtask
  // Live state reads
  task automatic t_live();
    live_q = 8'h5a;
    lvl_q = 8'ha5;
    host.pace(6);
    host.xfer(2'h0, 5'h10, 1'h1, g);
    host.xfer(2'h0, 5'h11, 1'h1, g);
    chk("bus live", g, 16'h005a);
    live_q = 8'h3c;
    host.pace(6);
    host.xfer(2'h0, 5'h10, 1'h1, g);
    chk("pin level", g, 16'h00a5);
    host.xfer(2'h0, 5'h10, 1'h0, g);
    chk("bus live new", g, 16'h003c);
    host.xfer(2'h3, 5'h0f, 1'h0, g);
    chk("live sel zero", g, 16'h0000);
  endtask
  // Cut frame is ignored, odd class answers zero
  task automatic t_short();
    sup_a = 8'h33;
    host.pace(6);
    sup_a = 8'h00;
    host.pace(6);
    host.cut({2'h3, 5'h0f, 1'h1, 1'h0, 7'h00}, 12);
    host.xfer(2'h3, 5'h0f, 1'h0, g);
    chk("cut no capture", g, 16'h0000);
    host.xfer(2'h1, 5'h0f, 1'h0, g);
    chk("cut no clear", g, 16'h0033);
    host.xfer(2'h2, 5'h10, 1'h1, g);
    chk("odd class", g, 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sup_a = 8'h00;
    sup_b = 8'h00;
    bus_a = 8'h00;
    bus_b = 8'h00;
    pin_f = 8'h00;
    wake_f = 8'h00;
    live_q = 8'h00;
    lvl_q = 8'h00;
    repeat (6) @(posedge clk_i);
    #1;
    arst_n_i = 1'h1;
    host.pace(4);
    t_latch();
    t_hold();
    t_map();
    t_live();
    t_short();
    report_and_stop();
  end
  // Hang guard
  initial begin
    #2_000_000;
    bad_count++;
    report_and_stop();
  end
endmodule
